//--- rtl/homing_pkg.sv
package homing_pkg;

    // Method code values held in the low digit of the method parameter.
    localparam logic [3:0] METHOD_CRADLE    = 4'h7;
    localparam logic [3:0] METHOD_FIRST_Z   = 4'h8;
    localparam logic [3:0] METHOD_FRONT_END = 4'hB;

    // Register byte offsets on the Wishbone slave.
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_METHOD    = 8'h04;
    localparam logic [7:0] OFS_HOME_SPD  = 8'h08;
    localparam logic [7:0] OFS_CREEP_SPD = 8'h0C;
    localparam logic [7:0] OFS_SHIFT     = 8'h10;
    localparam logic [7:0] OFS_HOME_POS  = 8'h14;
    localparam logic [7:0] OFS_ACCEL     = 8'h18;
    localparam logic [7:0] OFS_DECEL     = 8'h1C;
    localparam logic [7:0] OFS_STATUS    = 8'h20;
    localparam logic [7:0] OFS_CUR_POS   = 8'h24;

    // Control register field positions.
    localparam int CTRL_START   = 0;
    localparam int CTRL_DIR     = 1;
    localparam int CTRL_DOG_POL = 2;
    localparam int CTRL_ABORT   = 3;

    // Reset values of the parameters.
    localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
    localparam logic [3:0]  RST_METHOD = 4'h7;

    // Default widths.
    localparam int POS_W = 32;
    localparam int SPD_W = 16;

    // Values handed to the motion profile generator.
    typedef struct packed {
        logic        run;
        logic        reverse;
        logic [15:0] speed;
        logic [15:0] accel;
        logic [15:0] decel;
    } motion_cmd_s;

    // Host remote bits; manual mode and point select gate a home return.
    typedef struct packed {
        logic       manual_mode_select_bit;
        logic [7:0] point_select;
        logic       pos_speed_source_select;
    } host_bits_s;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEEK,
        ST_CREEP_Z,
        ST_REVERSE,
        ST_CLEAR_Z,
        ST_SHIFT,
        ST_DONE
    } home_state_e;

endpackage

//--- rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Two flop synchroniser for a bundle of independent level inputs.
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Asynchronous input and synchronised output.
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;  // First stage, read only by the second.
    logic [W-1:0] meta_d;  // Next value of the first stage.
    logic [W-1:0] sync_q;  // Second stage.
    logic [W-1:0] sync_d;  // Next value of the second stage.

    // Next values simply shift along the chain.
    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    // Both stages clear on reset so the output is defined at once.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;

endmodule
`default_nettype wire

//--- rtl/home_seq.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Method code 7 runs dog cradle.
// - Method code 8 runs first Z reference.
// - Direction follows direction parameter.
// - Home speed until dog is detected.
// - Creep speed held after dog detection.
// - Home offset by shift from Z point.
// - Accel and decel from first table entry.
// - Load current position with home value.
// - First Z: reverse at creep after dog.
// - First Z: latch at first Z after clearing.
// - Front end: dog front edge is home.
// - Cradle: home at first Z after dog.
module home_seq #(
    parameter int POS_W = homing_pkg::POS_W,
    parameter int SPD_W = homing_pkg::SPD_W
) (
    // Clock and reset.
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Wishbone classic slave.
    input  wire logic                    cyc_i,
    input  wire logic                    stb_i,
    input  wire logic                    we_i,
    input  wire logic [7:0]              adr_i,
    input  wire logic [3:0]              sel_i,
    input  wire logic [31:0]             dat_i,
    output logic      [31:0]             dat_o,
    output logic                         ack_o,
    // Host remote bits, already in this clock domain.
    input  wire homing_pkg::host_bits_s  host_i,
    // Field pins from the machine.
    input  wire logic                    dog_i,
    input  wire logic                    zphase_i,
    // Axis position from the encoder counter, same clock.
    input  wire logic [POS_W-1:0]        enc_pos_i,
    // Motion command and completion.
    output homing_pkg::motion_cmd_s      motion_o,
    output logic                         home_done_o,
    output logic      [POS_W-1:0]        cur_pos_o
);

    // Synchronised pins.
    logic [1:0] pins_s;
    pin_sync #(.W(2)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({dog_i, zphase_i}),
        .sync_o  (pins_s)
    );

    // Parameter registers.
    logic [3:0]       method_q,   method_d;
    logic             dir_q,      dir_d;
    logic             pol_q,      pol_d;
    logic [SPD_W-1:0] hspd_q,     hspd_d;
    logic [SPD_W-1:0] cspd_q,     cspd_d;
    logic [POS_W-1:0] shift_q,    shift_d;
    logic [POS_W-1:0] hpos_q,     hpos_d;
    logic [15:0]      acc_q,      acc_d;
    logic [15:0]      dec_q,      dec_d;
    logic             start_q,    start_d;   // One cycle start pulse.
    logic             abort_q,    abort_d;
    logic             ack_q,      ack_d;
    logic [31:0]      rdat_q,     rdat_d;
    // Sequencer state.
    homing_pkg::home_state_e st_q, st_d;
    logic [POS_W-1:0] zpos_q,     zpos_d;    // Latched Z or dog position.
    logic [POS_W-1:0] cur_q,      cur_d;
    logic             done_q,     done_d;
    logic             dog_prev_q, dog_prev_d;
    logic             z_prev_q,   z_prev_d;
    homing_pkg::motion_cmd_s mot_q, mot_d;

    // Dog active after polarity; Z rising edge on the second stage only.
    logic dog_act;
    logic z_edge;
    logic dog_rise;
    logic dog_fall;
    logic wr_en;
    logic hold_ok;
    assign dog_act  = pins_s[1] ^ pol_q;
    assign z_edge   = pins_s[0] & ~z_prev_q;
    assign dog_rise = dog_act & ~dog_prev_q;
    assign dog_fall = ~dog_act & dog_prev_q;
    assign wr_en    = cyc_i & stb_i & we_i & ~ack_q;
    // Home return is accepted only with manual mode on and no point chosen.
    assign hold_ok  = host_i.manual_mode_select_bit & (host_i.point_select == 8'h00);

    // Byte lane merge of a write into a 32 bit word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Register file write and read mux.
    always_comb begin
        method_d = method_q;
        dir_d    = dir_q;
        pol_d    = pol_q;
        hspd_d   = hspd_q;
        cspd_d   = cspd_q;
        shift_d  = shift_q;
        hpos_d   = hpos_q;
        acc_d    = acc_q;
        dec_d    = dec_q;
        start_d  = 1'b0;
        abort_d  = 1'b0;
        ack_d    = cyc_i & stb_i & ~ack_q;
        rdat_d   = homing_pkg::RST_ZERO;
        if (wr_en) begin
            case (adr_i)
                homing_pkg::OFS_CTRL: begin
                    if (sel_i[0]) begin
                        start_d = dat_i[homing_pkg::CTRL_START];
                        dir_d   = dat_i[homing_pkg::CTRL_DIR];
                        pol_d   = dat_i[homing_pkg::CTRL_DOG_POL];
                        abort_d = dat_i[homing_pkg::CTRL_ABORT];
                    end
                end
                homing_pkg::OFS_METHOD: begin
                    if (sel_i[0]) begin
                        method_d = dat_i[3:0];
                    end
                end
                homing_pkg::OFS_HOME_SPD:  hspd_d  = SPD_W'(merge(32'(hspd_q), dat_i, sel_i));
                homing_pkg::OFS_CREEP_SPD: cspd_d  = SPD_W'(merge(32'(cspd_q), dat_i, sel_i));
                homing_pkg::OFS_SHIFT:     shift_d = POS_W'(merge(32'(shift_q), dat_i, sel_i));
                homing_pkg::OFS_HOME_POS:  hpos_d  = POS_W'(merge(32'(hpos_q), dat_i, sel_i));
                homing_pkg::OFS_ACCEL:     acc_d   = 16'(merge(32'(acc_q), dat_i, sel_i));
                homing_pkg::OFS_DECEL:     dec_d   = 16'(merge(32'(dec_q), dat_i, sel_i));
                default: begin
                    // Writes elsewhere are acknowledged and dropped.
                end
            endcase
        end
        // Reads return the addressed word; unmapped reads give zero.
        case (adr_i)
            homing_pkg::OFS_CTRL:      rdat_d = {28'h0000000, 1'b0, pol_q, dir_q, 1'b0};
            homing_pkg::OFS_METHOD:    rdat_d = {28'h0000000, method_q};
            homing_pkg::OFS_HOME_SPD:  rdat_d = 32'(hspd_q);
            homing_pkg::OFS_CREEP_SPD: rdat_d = 32'(cspd_q);
            homing_pkg::OFS_SHIFT:     rdat_d = 32'(shift_q);
            homing_pkg::OFS_HOME_POS:  rdat_d = 32'(hpos_q);
            homing_pkg::OFS_ACCEL:     rdat_d = 32'(acc_q);
            homing_pkg::OFS_DECEL:     rdat_d = 32'(dec_q);
            homing_pkg::OFS_STATUS:    rdat_d = {25'h0, done_q, 3'h0, st_q};
            homing_pkg::OFS_CUR_POS:   rdat_d = 32'(cur_q);
            default:                   rdat_d = homing_pkg::RST_ZERO;
        endcase
    end

    // Register file flops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            method_q <= homing_pkg::RST_METHOD;
            dir_q    <= 1'b0;
            pol_q    <= 1'b0;
            hspd_q   <= '0;
            cspd_q   <= '0;
            shift_q  <= '0;
            hpos_q   <= '0;
            acc_q    <= 16'h0000;
            dec_q    <= 16'h0000;
            start_q  <= 1'b0;
            abort_q  <= 1'b0;
            ack_q    <= 1'b0;
            rdat_q   <= homing_pkg::RST_ZERO;
        end else begin
            method_q <= method_d;
            dir_q    <= dir_d;
            pol_q    <= pol_d;
            hspd_q   <= hspd_d;
            cspd_q   <= cspd_d;
            shift_q  <= shift_d;
            hpos_q   <= hpos_d;
            acc_q    <= acc_d;
            dec_q    <= dec_d;
            start_q  <= start_d;
            abort_q  <= abort_d;
            ack_q    <= ack_d;
            rdat_q   <= rdat_d;
        end
    end

    // Sequencer: walks the chosen method and drives the motion command.
    always_comb begin
        st_d       = st_q;
        zpos_d     = zpos_q;
        cur_d      = cur_q;
        done_d     = done_q;
        dog_prev_d = dog_act;
        z_prev_d   = pins_s[0];
        mot_d      = mot_q;
        mot_d.accel = acc_q;
        mot_d.decel = dec_q;
        case (st_q)
            homing_pkg::ST_IDLE: begin
                mot_d.run = 1'b0;
                if (start_q && hold_ok) begin
                    done_d        = 1'b0;
                    mot_d.run     = 1'b1;
                    mot_d.reverse = dir_q;
                    mot_d.speed   = hspd_q;
                    st_d          = homing_pkg::ST_SEEK;
                end
            end
            homing_pkg::ST_SEEK: begin
                // Home speed holds until the dog front end arrives.
                if (dog_rise) begin
                    mot_d.speed = cspd_q;
                    case (method_q)
                        homing_pkg::METHOD_CRADLE: st_d = homing_pkg::ST_CREEP_Z;
                        homing_pkg::METHOD_FIRST_Z: begin
                            mot_d.reverse = ~dir_q;
                            st_d          = homing_pkg::ST_REVERSE;
                        end
                        homing_pkg::METHOD_FRONT_END: begin
                            zpos_d = enc_pos_i;
                            st_d   = homing_pkg::ST_SHIFT;
                        end
                        default: begin
                            // Unsupported code: stop without homing.
                            mot_d.run = 1'b0;
                            st_d      = homing_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            homing_pkg::ST_CREEP_Z: begin
                if (z_edge) begin
                    zpos_d = enc_pos_i;
                    st_d   = homing_pkg::ST_SHIFT;
                end
            end
            homing_pkg::ST_REVERSE: begin
                // Wait at creep until the axis has left the dog.
                if (dog_fall) begin
                    st_d = homing_pkg::ST_CLEAR_Z;
                end
            end
            homing_pkg::ST_CLEAR_Z: begin
                if (z_edge) begin
                    zpos_d = enc_pos_i;
                    st_d   = homing_pkg::ST_SHIFT;
                end
            end
            homing_pkg::ST_SHIFT: begin
                // Move by the shift distance away from the latched point.
                if ((enc_pos_i - zpos_q) == shift_q || (zpos_q - enc_pos_i) == shift_q) begin
                    mot_d.run = 1'b0;
                    cur_d     = hpos_q;
                    st_d      = homing_pkg::ST_DONE;
                end
            end
            homing_pkg::ST_DONE: begin
                done_d = 1'b1;
                st_d   = homing_pkg::ST_IDLE;
            end
            default: st_d = homing_pkg::ST_IDLE;
        endcase
        if (abort_q) begin
            mot_d.run = 1'b0;
            st_d      = homing_pkg::ST_IDLE;
        end
    end

    // Sequencer flops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q       <= homing_pkg::ST_IDLE;
            zpos_q     <= '0;
            cur_q      <= '0;
            done_q     <= 1'b0;
            dog_prev_q <= 1'b0;
            z_prev_q   <= 1'b0;
            mot_q      <= '0;
        end else begin
            st_q       <= st_d;
            zpos_q     <= zpos_d;
            cur_q      <= cur_d;
            done_q     <= done_d;
            dog_prev_q <= dog_prev_d;
            z_prev_q   <= z_prev_d;
            mot_q      <= mot_d;
        end
    end

    assign dat_o       = rdat_q;
    assign ack_o       = ack_q;
    assign motion_o    = mot_q;
    assign home_done_o = done_q;
    assign cur_pos_o   = cur_q;

    // Checks.
    chk_seek_speed: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == homing_pkg::ST_SEEK && !$past(st_q == homing_pkg::ST_IDLE) |-> mot_q.speed == hspd_q) else $error("seek speed wrong");
    chk_creep_speed: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(st_q == homing_pkg::ST_SEEK) && st_q == homing_pkg::ST_CREEP_Z |-> mot_q.speed == cspd_q) else $error("creep not applied");
    chk_reverse_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == homing_pkg::ST_REVERSE |-> mot_q.reverse == ~dir_q) else $error("no reversal");
    chk_done_load: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == homing_pkg::ST_DONE |-> cur_q == hpos_q ##1 done_q) else $error("done without load");
    chk_accel_use: assert property (@(posedge clk_i) disable iff (rst_i)
        mot_q.accel == $past(acc_q)) else $error("accel mismatch");
    chk_method_cradle: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == homing_pkg::ST_CREEP_Z |-> method_q == homing_pkg::METHOD_CRADLE || $changed(method_q)) else $error("cradle path");
    chk_method_firstz: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == homing_pkg::ST_CLEAR_Z |-> $past(st_q) inside {homing_pkg::ST_REVERSE, homing_pkg::ST_CLEAR_Z}) else $error("first z order");
    chk_start_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == homing_pkg::ST_IDLE && start_q && !hold_ok && !abort_q |=> st_q == homing_pkg::ST_IDLE) else $error("started without manual mode");

endmodule
`default_nettype wire

//--- bench/axis_model.sv
`timescale 1ns/10ps
`default_nettype none
// Behavioural machine axis: one count per cycle while running, a dog band and a Z mark every 16 counts.
module axis_model #(
    parameter int DOG_LO = 165,
    parameter int DOG_HI = 215
) (
    // Clock.
    input  wire logic                    clk_i,
    // Motion command from the sequencer.
    input  wire homing_pkg::motion_cmd_s motion_i,
    // Position preset and dog wiring sense.
    input  wire logic                    load_i,
    input  wire logic [31:0]             preset_i,
    input  wire logic                    dog_inv_i,
    // Machine signals.
    output logic      [31:0]             pos_o,
    output logic                         dog_o,
    output logic                         zphase_o
);
    // Travel ignores the speed value; only direction and run matter to the position count.
    always_ff @(posedge clk_i) begin
        if (load_i) begin
            pos_o <= preset_i;
        end else if (motion_i.run) begin
            pos_o <= motion_i.reverse ? pos_o - 32'h1 : pos_o + 32'h1;
        end
    end
    // An inverted dog wiring idles high, so a design that ignores the sense sees a dog at once.
    assign dog_o    = ((pos_o >= DOG_LO) && (pos_o <= DOG_HI)) ^ dog_inv_i;
    // The Z mark lasts exactly one count, so a missed edge is not hidden by a wide pulse.
    assign zphase_o = (pos_o[3:0] == 4'h0);
endmodule
`default_nettype wire

//--- bench/servo_homing_z_phase_dog_modes_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
// Wishbone-driven bench for the home-return sequencer against a behavioural axis.
module servo_homing_z_phase_dog_modes_bench;
    logic                    clk_i;     // System clock.
    logic                    rst_i;     // Synchronous reset.
    logic                    cyc;       // Bus cycle.
    logic                    stb;       // Bus strobe.
    logic                    we;        // Bus direction.
    logic [7:0]              adr;       // Bus address.
    logic [3:0]              sel;       // Byte lanes.
    logic [31:0]             dat_w;     // Write data.
    logic [31:0]             dat_o;     // Read data.
    logic                    ack_o;     // Bus answer.
    logic [31:0]             q;         // Last read value.
    homing_pkg::host_bits_s  host;      // Host remote bits.
    homing_pkg::motion_cmd_s motion;    // Motion command.
    logic                    dog;       // Dog pin.
    logic                    zph;       // Z pin.
    logic [31:0]             enc;       // Axis position.
    logic                    home_done; // Completion level.
    logic [31:0]             cur_pos;   // Current position.
    logic                    load;      // Axis preset strobe.
    logic [31:0]             preset;    // Axis preset value.
    logic                    dog_inv;   // Dog wiring sense.
    int                      errors;
    int                      compares;
    int                      cycles;

    // Clock at 250 MHz.
    always #2 clk_i = ~clk_i;

    home_seq home_seq_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat_w), .dat_o(dat_o), .ack_o(ack_o), .host_i(host), .dog_i(dog),
        .zphase_i(zph), .enc_pos_i(enc), .motion_o(motion), .home_done_o(home_done), .cur_pos_o(cur_pos));

    axis_model axis_model_i (.clk_i(clk_i), .motion_i(motion), .load_i(load), .preset_i(preset),
        .dog_inv_i(dog_inv), .pos_o(enc), .dog_o(dog), .zphase_o(zph));

    // Prints the counts and the verdict, then stops the run.
    task automatic final_report();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // One classic cycle; the request holds until the rising edge where ack is sampled high, and data is taken there.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        sel   <= 4'hF;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Places the axis, selects the method and requests a home return.
    task automatic start_home(input logic [3:0] m, input logic dir, input logic inv, input logic [31:0] p);
        @(posedge clk_i);
        preset  <= p;
        load    <= 1'b1;
        dog_inv <= inv;
        @(posedge clk_i);
        load <= 1'b0;
        wb(1'b1, homing_pkg::OFS_METHOD, {28'h0000000, m});
        wb(1'b1, homing_pkg::OFS_CTRL, {29'h0, inv, dir, 1'b1});
    endtask

    // A hang is cut short well beyond the hundred or so cycles each home return needs.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    // Parameter values for every home return, home value replaced before the front end test; all fit the 16-bit speed fields.
    logic [7:0]  ofs [6] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    logic [31:0] val [6] = '{32'h200, 32'h20, 32'h5, 32'h1234, 32'h11, 32'h22};

    initial begin
        clk_i = 1'b0; rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
        dat_w = 32'h0; host = '0; load = 1'b1; preset = 32'h64; dog_inv = 1'b0;
        errors = 0; compares = 0; cycles = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        load  <= 1'b0;
        // Reset values, an unmapped place and read-back of the six parameters from home speed to decel.
        wb(1'b0, homing_pkg::OFS_METHOD, 32'h0);
        `CHK(q, 32'h00000007)
        wb(1'b0, homing_pkg::OFS_STATUS, 32'h0);
        `CHK(q, 32'h00000000)
        wb(1'b0, 8'h30, 32'h0);
        `CHK(q, 32'h00000000)
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, ofs[i], val[i]);
            wb(1'b0, ofs[i], 32'h0);
            `CHK(q, val[i])
        end
        $display("test registers done");
        // Without manual mode, and with a point bit set, a start is ignored.
        start_home(4'h7, 1'b0, 1'b0, 32'h64);
        repeat (20) @(negedge clk_i);
        `CHK(motion.run, 1'b0)
        @(posedge clk_i);
        host.manual_mode_select_bit <= 1'b1;
        host.pos_speed_source_select <= 1'b1;
        host.point_select           <= 8'h80;
        start_home(4'h7, 1'b0, 1'b0, 32'h64);
        repeat (20) @(negedge clk_i);
        `CHK(motion.run, 1'b0)
        @(posedge clk_i);
        host.point_select <= 8'h00;
        $display("test refusal done");
        // Dog cradle, forward, plain dog: Z mark at 0xB0, home shifted by 5.
        start_home(homing_pkg::METHOD_CRADLE, 1'b0, 1'b0, 32'h64);
        while (motion.run !== 1'b1) @(negedge clk_i);
        `CHK(motion.speed, 16'h0200)
        `CHK(motion.reverse, 1'b0)
        `CHK({motion.accel, motion.decel}, 32'h00110022)
        while (motion.speed !== 16'h0020) @(negedge clk_i);
        `CHK(enc >= 32'hA5, 1'b1)
        `CHK(motion.reverse, 1'b0)
        while (home_done !== 1'b1) @(negedge clk_i);
        `CHK(cur_pos, 32'h00001234)
        `CHK(motion.run, 1'b0)
        `CHK((enc >= 32'hB5) && (enc <= 32'hBE), 1'b1)
        wb(1'b0, homing_pkg::OFS_STATUS, 32'h0);
        `CHK(q[6], 1'b1)
        $display("test cradle done");
        // First Z method, reverse seek, inverted dog: reverse at creep, Z mark at 0xE0 after clearing.
        start_home(homing_pkg::METHOD_FIRST_Z, 1'b1, 1'b1, 32'h104);
        while (motion.run !== 1'b1) @(negedge clk_i);
        `CHK(motion.reverse, 1'b1)
        `CHK(home_done, 1'b0)
        while (motion.speed !== 16'h0020) @(negedge clk_i);
        repeat (2) @(negedge clk_i);
        `CHK(motion.reverse, 1'b0)
        while (home_done !== 1'b1) @(negedge clk_i);
        `CHK(cur_pos, 32'h00001234)
        `CHK((enc >= 32'hE5) && (enc <= 32'hEE), 1'b1)
        $display("test first z done");
        // Front end method: home at the dog front, no Z needed; a fresh home value proves the load happens again.
        wb(1'b1, homing_pkg::OFS_HOME_POS, 32'h00005678);
        start_home(homing_pkg::METHOD_FRONT_END, 1'b0, 1'b0, 32'h64);
        while (motion.run !== 1'b1) @(negedge clk_i);
        while (home_done !== 1'b1) @(negedge clk_i);
        `CHK(cur_pos, 32'h00005678)
        `CHK((enc >= 32'hA5) && (enc <= 32'hAF), 1'b1)
        $display("test front end done");
        // Abort in mid-seek returns to idle with no completion.
        start_home(homing_pkg::METHOD_CRADLE, 1'b0, 1'b0, 32'h10);
        while (motion.run !== 1'b1) @(negedge clk_i);
        wb(1'b1, homing_pkg::OFS_CTRL, 32'h00000008);
        repeat (4) @(negedge clk_i);
        `CHK(motion.run, 1'b0)
        wb(1'b0, homing_pkg::OFS_STATUS, 32'h0);
        `CHK(q[6:0], 7'h00)
        $display("test abort done");
        // An unknown method code runs to the dog and stops there without completing.
        start_home(4'h3, 1'b0, 1'b0, 32'h64);
        while (motion.run !== 1'b1) @(negedge clk_i);
        while (motion.run === 1'b1) @(negedge clk_i);
        `CHK(enc >= 32'hA5, 1'b1)
        `CHK(home_done, 1'b0)
        wb(1'b0, homing_pkg::OFS_STATUS, 32'h0);
        `CHK(q[6:0], 7'h00)
        $display("test unknown method done");
        final_report();
    end
endmodule
`default_nettype wire
